// ---- core/usb_ep_pkg.sv ----
// constants and carrier types of the usb endpoint bookkeeping block
`default_nettype none
package usb_ep_pkg;
    // register indices; byte address on the bus is four times the index
    localparam logic [5:0] IDX_ISTAT = 6'h20;
    localparam logic [5:0] IDX_IMASK = 6'h21;
    localparam logic [5:0] IDX_CTL   = 6'h22;
    localparam logic [5:0] IDX_DEVICE_ADDRESS = 6'h23;
    localparam logic [5:0] IDX_LSTAT = 6'h24;
    localparam logic [5:0] IDX_EP0   = 6'h25;
    localparam logic [5:0] IDX_RXC0  = 6'h26;
    localparam logic [5:0] IDX_EP2RX = 6'h2A;
    localparam logic [5:0] IDX_RXC2  = 6'h2B;
    localparam logic [5:0] IDX_ERRS  = 6'h34;
    // per-endpoint transmit control / count indices, entry 0 unused for control
    localparam logic [5:0] IDX_TXCTL [6] = '{6'h25, 6'h28, 6'h2C, 6'h2E, 6'h30, 6'h32};
    localparam logic [5:0] IDX_TXCNT [6] = '{6'h27, 6'h29, 6'h2D, 6'h2F, 6'h31, 6'h33};
    // endpoint status encoding, also used as handshake code
    localparam logic [1:0] ST_DISABLED = 2'h0;
    localparam logic [1:0] ST_STALL    = 2'h1;
    localparam logic [1:0] ST_NAK      = 2'h2;
    localparam logic [1:0] ST_VALID    = 2'h3;
    // token kinds
    localparam logic [1:0] KIND_OUT   = 2'h0;
    localparam logic [1:0] KIND_IN    = 2'h1;
    localparam logic [1:0] KIND_SETUP = 2'h2;
    // field positions and reset values
    localparam int         ISTAT_DONE  = 7;
    localparam int         ISTAT_ERR   = 4;
    localparam int         ISTAT_RESET = 1;
    localparam int         CTL_FORCE   = 0;
    localparam logic [7:0] CTL_RESET   = 8'h06;
    localparam logic [7:0] CTL_WMASK   = 8'hCF;
    localparam logic [7:0] ISTAT_WMASK = 8'hBF;
    localparam logic [7:0] DEVICE_ADDRESS_WMASK = 8'h7F;
    localparam logic [7:0] ERRS_WMASK  = 8'h07;
    localparam logic [6:0] CNT_NARROW  = 7'h0F;
    localparam logic [6:0] CNT_WIDE    = 7'h7F;
    localparam logic [2:0] EP_WIDE     = 3'h2;
    localparam logic [2:0] EP_LAST     = 3'h5;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one token and its outcome from the serial engine
    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic [2:0] ep;
        logic [1:0] kind;
        logic [6:0] bytes;
        logic       ok;
    } xfer_t;

    // answer to the serial engine
    typedef struct packed {
        logic       valid;
        logic [1:0] code;
        logic [6:0] count;
    } hs_t;

    // whole state of the block
    typedef struct packed {
        logic [2:0]      rst_sync;
        logic            bus_rst;
        logic [7:0]      istat;
        logic [7:0]      imask;
        logic [7:0]      ctl;
        logic [7:0]      device_address;
        logic [7:0]      lstat;
        logic [7:0]      errs;
        logic [5:0]      done_tx;
        logic [5:0]      tog_tx;
        logic [5:0][1:0] stat_tx;
        logic [5:0][6:0] tx_cnt;
        logic            done_rx2;
        logic [1:0]      tog_rx;
        logic [1:0][1:0] stat_rx;
        logic [1:0][6:0] rx_cnt;
        logic            aw_got;
        logic            w_got;
        logic [5:0]      aw_idx;
        logic [7:0]      wdata;
        logic            w_en;
        logic            awready;
        logic            wready;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [1:0]      rresp;
        logic [7:0]      rdata;
        hs_t             hs;
    } state_t;
endpackage
`default_nettype wire

// ---- core/usb_ep_regs.sv ----
// usb endpoint status, byte counts and register map behind an axi4-lite slave
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module usb_ep_regs
    import usb_ep_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input  wire logic              CLOCK_I,
    input  wire logic              RST_N_I,
    input  wire logic [ADDR_W-1:0] AXI_AWADDR_I,
    input  wire logic              AXI_AWVALID_I,
    output var  logic              AXI_AWREADY_O,
    input  wire logic [31:0]       AXI_WDATA_I,
    input  wire logic [3:0]        AXI_WSTRB_I,
    input  wire logic              AXI_WVALID_I,
    output var  logic              AXI_WREADY_O,
    output var  logic [1:0]        AXI_BRESP_O,
    output var  logic              AXI_BVALID_O,
    input  wire logic              AXI_BREADY_I,
    input  wire logic [ADDR_W-1:0] AXI_ARADDR_I,
    input  wire logic              AXI_ARVALID_I,
    output var  logic              AXI_ARREADY_O,
    output var  logic [31:0]       AXI_RDATA_O,
    output var  logic [1:0]        AXI_RRESP_O,
    output var  logic              AXI_RVALID_O,
    input  wire logic              AXI_RREADY_I,
    input  wire logic              BUS_RESET_I,
    input  wire xfer_t             XFER_I,
    output var  hs_t               HS_O
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // true for any mapped register index
    function automatic logic reg_hit(input logic [5:0] idx);
        return (idx >= IDX_ISTAT) && (idx <= IDX_ERRS);
    endfunction

    // only endpoint 2 carries wide counts
    function automatic logic [6:0] cnt_mask(input logic [2:0] ep);
        return (ep == EP_WIDE) ? CNT_WIDE : CNT_NARROW;
    endfunction

    // read value of one register, unused bits zero
    function automatic logic [7:0] rd_val(input state_t s, input logic [5:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            IDX_ISTAT: v = s.istat;
            IDX_IMASK: v = s.imask;
            IDX_CTL:   v = s.ctl;
            IDX_DEVICE_ADDRESS: v = s.device_address;
            IDX_LSTAT: v = s.lstat;
            IDX_EP0:   v = {s.done_tx[0], s.tog_tx[0], s.stat_tx[0], 1'b0,
                            s.tog_rx[0], s.stat_rx[0]};
            IDX_RXC0:  v = {1'b0, s.rx_cnt[0]};
            IDX_EP2RX: v = {4'h0, s.done_rx2, s.tog_rx[1], s.stat_rx[1]};
            IDX_RXC2:  v = {1'b0, s.rx_cnt[1]};
            IDX_ERRS:  v = s.errs;
            default:   v = 8'h00;
        endcase
        // endpoint transmit registers, looked up from the index tables
        for (int e = 0; e < 6; e++)
        begin
            if (e > 0 && idx == IDX_TXCTL[e])
                v = {4'h0, s.done_tx[e], s.tog_tx[e], s.stat_tx[e]};
            if (idx == IDX_TXCNT[e])
                v = {1'b0, s.tx_cnt[e]};
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    state_t     s_reg;      // all flops
    state_t     s_next;     // next value
    logic       usb_rst;    // bus or forced reset level
    logic       wr_go;      // address and data both held
    logic [7:0] wd;         // write byte
    logic [2:0] ep;         // token endpoint
    logic       ri;         // receive slot: 0 for ep0, 1 for ep2
    logic       has_rx;     // endpoint has a receive side
    logic       is_rx;      // out or setup token
    logic       tok;        // token accepted for this device
    logic [1:0] code;       // handshake picked

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        s_next  = s_reg;
        usb_rst = s_reg.bus_rst | s_reg.ctl[CTL_FORCE];
        wd      = s_reg.wdata;
        ep      = XFER_I.ep;
        ri      = (ep == EP_WIDE);
        has_rx  = (ep == 3'h0) || ri;
        is_rx   = (XFER_I.kind != KIND_IN);
        tok     = XFER_I.valid && !usb_rst && (ep <= EP_LAST)
                  && (XFER_I.addr == s_reg.device_address[6:0]);
        code    = ST_DISABLED;

        // pin synchroniser; a change counts once stages two and three agree
        s_next.rst_sync = {s_reg.rst_sync[1:0], BUS_RESET_I};
        if (s_reg.rst_sync[1] == s_reg.rst_sync[2])
            s_next.bus_rst = s_reg.rst_sync[2];

        // write address and data may come in either order
        if (AXI_AWVALID_I && s_reg.awready)
        begin
            s_next.aw_got = 1'b1;
            s_next.aw_idx = AXI_AWADDR_I[7:2];
        end
        if (AXI_WVALID_I && s_reg.wready)
        begin
            s_next.w_got = 1'b1;
            s_next.wdata = AXI_WDATA_I[7:0];
            s_next.w_en  = AXI_WSTRB_I[0];
        end
        if (AXI_BREADY_I && s_reg.bvalid)
            s_next.bvalid = 1'b0;
        wr_go = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
        if (wr_go)
        begin
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp  = reg_hit(s_reg.aw_idx) ? RESP_OKAY : RESP_SLVERR;
        end
        // ready only while the holding slot is free
        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready  = !s_next.w_got && !s_next.bvalid;

        // register write; flags clear on a written zero, one leaves them
        if (wr_go && s_reg.w_en)
        begin
            unique case (s_reg.aw_idx)
                IDX_ISTAT: s_next.istat = s_reg.istat & (wd | ~ISTAT_WMASK);
                IDX_IMASK: s_next.imask = wd & ISTAT_WMASK;
                IDX_CTL:   s_next.ctl   = wd & CTL_WMASK;
                IDX_DEVICE_ADDRESS: s_next.device_address = wd & DEVICE_ADDRESS_WMASK;
                IDX_ERRS:  s_next.errs  = s_reg.errs & wd & ERRS_WMASK;
                IDX_EP0:
                begin
                    s_next.done_tx[0] = s_reg.done_tx[0] & wd[7];
                    s_next.tog_tx[0]  = wd[6];
                    s_next.stat_tx[0] = wd[5:4];
                    s_next.tog_rx[0]  = wd[2];
                    s_next.stat_rx[0] = wd[1:0];
                end
                IDX_EP2RX:
                begin
                    s_next.done_rx2   = s_reg.done_rx2 & wd[3];
                    s_next.tog_rx[1]  = wd[2];
                    s_next.stat_rx[1] = wd[1:0];
                end
                IDX_RXC0: s_next.rx_cnt[0] = wd[6:0] & CNT_NARROW;
                IDX_RXC2: s_next.rx_cnt[1] = wd[6:0] & CNT_WIDE;
                default:  s_next.istat = s_next.istat;
            endcase
            // transmit control and counts, upper bits dropped
            for (int e = 0; e < 6; e++)
            begin
                if (e > 0 && s_reg.aw_idx == IDX_TXCTL[e])
                begin
                    s_next.done_tx[e] = s_reg.done_tx[e] & wd[3];
                    s_next.tog_tx[e]  = wd[2];
                    s_next.stat_tx[e] = wd[1:0];
                end
                if (s_reg.aw_idx == IDX_TXCNT[e])
                    s_next.tx_cnt[e] = wd[6:0] & cnt_mask(3'(e));
            end
        end

        // flag a fresh bus reset after the write, so an event beats a same-cycle clear
        if (s_next.bus_rst && !s_reg.bus_rst)
            s_next.istat[ISTAT_RESET] = 1'b1;

        // read channel; one read in flight
        if (AXI_RREADY_I && s_reg.rvalid)
            s_next.rvalid = 1'b0;
        if (AXI_ARVALID_I && s_reg.arready)
        begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = rd_val(s_reg, AXI_ARADDR_I[7:2]);
            s_next.rresp  = reg_hit(AXI_ARADDR_I[7:2]) ? RESP_OKAY : RESP_SLVERR;
        end
        s_next.arready = !s_next.rvalid;

        // usb reset wipes toggles and status; counts stay for software
        if (usb_rst)
        begin
            s_next.tog_tx  = '0;
            s_next.stat_tx = '0;
            s_next.tog_rx  = '0;
            s_next.stat_rx = '0;
        end

        // token from the serial engine; hardware wins over a same-cycle write
        s_next.hs.valid = 1'b0;
        if (tok)
        begin
            if (XFER_I.kind == KIND_SETUP)
                // setup only on ep0 and taken unless disabled
                code = (ep == 3'h0 && s_reg.stat_rx[0] != ST_DISABLED) ? ST_VALID
                                                                        : ST_DISABLED;
            else if (is_rx)
                code = has_rx ? s_reg.stat_rx[ri] : ST_DISABLED;
            else
                code = s_reg.stat_tx[ep];
            s_next.hs.valid = (code != ST_DISABLED);
            s_next.hs.code  = code;
            // limit handed to the engine: allocation or bytes to send
            s_next.hs.count = is_rx ? s_reg.rx_cnt[ri] : s_reg.tx_cnt[ep];

            if (code == ST_VALID && XFER_I.ok)
            begin
                s_next.istat[ISTAT_DONE] = 1'b1;
                s_next.lstat = {XFER_I.kind, !is_rx, 2'b00, ep};
                if (is_rx)
                begin
                    // saturate; an oversize packet would wrap otherwise
                    s_next.rx_cnt[ri] = (XFER_I.bytes > s_reg.rx_cnt[ri]) ? 7'h00
                                        : s_reg.rx_cnt[ri] - XFER_I.bytes;
                    s_next.stat_rx[ri] = ST_NAK;
                    if (ri)
                        s_next.done_rx2 = 1'b1;
                    else
                        s_next.done_tx[0] = 1'b1;
                    if (XFER_I.kind == KIND_SETUP)
                    begin
                        // setup data is data0; next expected data1
                        s_next.tog_rx[0]  = 1'b1;
                        s_next.tog_tx[0]  = 1'b1;
                        s_next.stat_tx[0] = ST_NAK;
                    end
                    else
                        s_next.tog_rx[ri] = !s_reg.tog_rx[ri];
                    if (!ri)
                        s_next.stat_tx[0] = ST_NAK;
                end
                else
                begin
                    s_next.done_tx[ep] = 1'b1;
                    s_next.tog_tx[ep]  = !s_reg.tog_tx[ep];
                    s_next.stat_tx[ep] = ST_NAK;
                    if (ep == 3'h0)
                        s_next.stat_rx[0] = ST_NAK;
                end
            end
            else if (code == ST_VALID)
                s_next.istat[ISTAT_ERR] = 1'b1;               // bad packet seen
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            s_reg         <= '0;
            s_reg.ctl    <= CTL_RESET;
            s_reg.awready <= 1'b1;
            s_reg.wready  <= 1'b1;
            s_reg.arready <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state flops
    assign AXI_AWREADY_O = s_reg.awready;
    assign AXI_WREADY_O  = s_reg.wready;
    assign AXI_BVALID_O  = s_reg.bvalid;
    assign AXI_BRESP_O   = s_reg.bresp;
    assign AXI_ARREADY_O = s_reg.arready;
    assign AXI_RVALID_O  = s_reg.rvalid;
    assign AXI_RRESP_O   = s_reg.rresp;
    assign AXI_RDATA_O   = {24'h000000, s_reg.rdata};
    assign HS_O          = s_reg.hs;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // ep2 receive stalled: stall answer next cycle
    stall_answer_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        tok && XFER_I.kind == KIND_OUT && ep == EP_WIDE
        && s_reg.stat_rx[1] == ST_STALL |=> HS_O.valid && HS_O.code == ST_STALL)
        else $error("stalled endpoint did not answer stall");

    // ep2 receive naked: nak answer next cycle
    nak_answer_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        tok && XFER_I.kind == KIND_OUT && ep == EP_WIDE
        && s_reg.stat_rx[1] == ST_NAK |=> HS_O.valid && HS_O.code == ST_NAK)
        else $error("naked endpoint did not answer nak");

    // ack to an out token only ever from a valid status
    ack_valid_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        tok && is_rx && has_rx && XFER_I.kind == KIND_OUT
        |=> HS_O.code == $past(s_reg.stat_rx[ri]))
        else $error("handshake code differs from status");

    // good reception leaves status at nak and done flag up
    rx_done_nak_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        tok && XFER_I.ok && XFER_I.kind == KIND_OUT && ep == EP_WIDE
        && s_reg.stat_rx[1] == ST_VALID |=> s_reg.stat_rx[1] == ST_NAK && s_reg.done_rx2)
        else $error("good reception did not nak and flag");

    // remaining count is allocation minus bytes
    rx_remain_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        tok && XFER_I.ok && XFER_I.kind == KIND_OUT && ep == EP_WIDE
        && s_reg.stat_rx[1] == ST_VALID && XFER_I.bytes <= s_reg.rx_cnt[1]
        |=> s_reg.rx_cnt[1] == $past(s_reg.rx_cnt[1]) - $past(XFER_I.bytes))
        else $error("receive count not decremented by bytes");

    // in token hands over the transmit count
    tx_count_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        tok && XFER_I.kind == KIND_IN |=> HS_O.count == $past(s_reg.tx_cnt[ep]))
        else $error("transmit count not presented");

    // narrow counts rx0 and tx3 never show upper bits
    cnt_upper_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        s_reg.rx_cnt[0][6:4] == 3'h0 && s_reg.tx_cnt[3][6:4] == 3'h0)
        else $error("narrow count upper bits set");

    // reset level clears low control bits by the next edge
    usb_reset_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        usb_rst |=> s_reg.stat_rx == '0 && s_reg.stat_tx == '0
        && s_reg.tog_rx == '0 && s_reg.tog_tx == '0)
        else $error("usb reset left control bits set");

    // count write lands masked next edge
    cnt_write_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        wr_go && s_reg.w_en && s_reg.aw_idx == IDX_RXC2 && !tok
        |=> s_reg.rx_cnt[1] == ($past(s_reg.wdata[6:0]) & CNT_WIDE))
        else $error("count write not stored");

endmodule
`default_nettype wire

// ---- test/usb_host_model.sv ----
// host side model: issues usb tokens and drives the bus reset line
`default_nettype none
module usb_host_model
    import usb_ep_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h05
)(
    input  wire logic  CLOCK_I,
    input  wire hs_t   HS_I,
    output var  xfer_t XFER_O,
    output var  logic  BUS_RESET_O
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////
    // idle line: no token, bus reset released
    initial
    begin
        XFER_O = '0;
        BUS_RESET_O = 1'b0;
    end
    // one correct token; the answer is sampled one cycle after the take
    task automatic send(input logic [2:0] ep, input logic [1:0] kind,
                        input logic [6:0] n, output hs_t hs);
        XFER_O <= '{valid: 1'b1, addr: DEV_ADDR, ep: ep, kind: kind, bytes: n, ok: 1'b1};
        @(posedge CLOCK_I);
        // released fields change, so a stale token cannot look valid
        XFER_O <= {1'b0, ~DEV_ADDR, ~ep, 2'h3, ~n, 1'b0};
        @(posedge CLOCK_I);
        hs = HS_I;
    endtask
    // level of the bus reset seen by the transceiver
    task automatic hold_reset(input logic lvl);
        BUS_RESET_O <= lvl;
    endtask
endmodule
`default_nettype wire

// ---- test/test_usb_endpoint_count_and_status.sv ----
// self-checking bench for the usb endpoint count and status block
`default_nettype none
module test_usb_endpoint_count_and_status;
    import usb_ep_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////
    logic        clk;                       // 200 MHz system clock
    logic        rst_n;                     // async reset, active low
    logic [7:0]  awaddr, araddr;            // byte addresses
    logic [31:0] wdata, rdata;              // bus data
    logic        awvalid, wvalid, arvalid;  // requests
    logic        awready, wready, arready;  // slave ready
    logic        bvalid, rvalid;            // answers
    logic [1:0]  bresp, rresp, last_resp;   // response codes
    logic        bus_rst;                   // bus reset from the host
    xfer_t       xfer;                      // token from the host
    hs_t         hs_w;                      // handshake to the host
    int          miscompares, cmp_count;    // tallies
    ////////////////////////////////////////////////////////////////////////////
    usb_ep_regs dut_u (
        .CLOCK_I(clk), .RST_N_I(rst_n), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid),
        .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'h1),
        .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp),
        .AXI_BVALID_O(bvalid), .AXI_BREADY_I(1'b1), .AXI_ARADDR_I(araddr),
        .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata),
        .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(1'b1),
        .BUS_RESET_I(bus_rst), .XFER_I(xfer), .HS_O(hs_w));
    usb_host_model host_u (.CLOCK_I(clk), .HS_I(hs_w), .XFER_O(xfer), .BUS_RESET_O(bus_rst));
    // clock: toggles every half period
    always #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // compare seen against expected
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // bounded wait ran out: counts as a mismatch and ends the run
    task automatic timed_out(input string what);
        miscompares++;
        $display("ERROR %s expected answer seen none", what);
        tally_and_finish();
    endtask
    // axi write; ready lines of both answers are held high throughout
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        int n;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        if (n == 64)
            timed_out("write answer");
        last_resp = bresp;
    endtask
    // axi read of one word, low byte returned
    task automatic rd(input logic [5:0] idx, output logic [7:0] d);
        int n;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        if (n == 64)
            timed_out("read answer");
        d = rdata[7:0];
        last_resp = rresp;
    endtask
    task automatic rd_check(input string what, input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        rd(idx, d);
        check(what, d, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // reset value and width of every count register
    task automatic count_regs();
        int i;
        for (i = 0; i < 6; i++)
        begin
            rd_check("tx count reset", IDX_TXCNT[i], 8'h00);
            wr(IDX_TXCNT[i], 8'hFF);
            rd_check("tx count width", IDX_TXCNT[i], (i == 2) ? 8'h7F : 8'h0F);
        end
        rd_check("rx0 count reset", IDX_RXC0, 8'h00);
        rd_check("rx2 count reset", IDX_RXC2, 8'h00);
        wr(IDX_RXC0, 8'hFF);
        rd_check("rx0 count width", IDX_RXC0, 8'h0F);
        wr(IDX_RXC2, 8'hFF);
        rd_check("rx2 count width", IDX_RXC2, 8'h7F);
    endtask
    // holes in the map answer with an error and zero data
    task automatic unmapped();
        wr(6'h10, 8'hFF);
        check("unmapped write resp", {6'h00, last_resp}, {6'h00, RESP_SLVERR});
        rd_check("unmapped read data", 6'h35, 8'h00);
        check("unmapped read resp", {6'h00, last_resp}, {6'h00, RESP_SLVERR});
    endtask
    // endpoint 2 reception through all four status codes
    task automatic out_flow();
        hs_t hs;
        wr(IDX_DEVICE_ADDRESS, 8'h05);
        wr(IDX_RXC2, 8'h14);
        wr(IDX_EP2RX, 8'h03);
        host_u.send(3'h2, KIND_OUT, 7'h05, hs);
        check("ack code", {5'h00, hs.valid, hs.code}, {6'h01, ST_VALID});
        check("answer count", {1'b0, hs.count}, 8'h14);
        rd_check("rx2 remainder", IDX_RXC2, 8'h0F);
        rd_check("rx2 control", IDX_EP2RX, 8'h0E);
        host_u.send(3'h2, KIND_OUT, 7'h01, hs);
        check("nak code", {5'h00, hs.valid, hs.code}, {6'h01, ST_NAK});
        wr(IDX_EP2RX, 8'h01);
        host_u.send(3'h2, KIND_OUT, 7'h01, hs);
        check("stall code", {5'h00, hs.valid, hs.code}, {6'h01, ST_STALL});
        wr(IDX_EP2RX, 8'h00);
        host_u.send(3'h2, KIND_OUT, 7'h01, hs);
        check("disabled silent", {7'h00, hs.valid}, 8'h00);
        rd_check("rx2 count kept", IDX_RXC2, 8'h0F);
    endtask
    // in tokens hand over the transmit count; counts left at full width by count_regs
    task automatic in_flow();
        hs_t hs;
        wr(IDX_TXCTL[2], 8'h03);
        host_u.send(3'h2, KIND_IN, 7'h00, hs);
        check("ep2 in code", {5'h00, hs.valid, hs.code}, {6'h01, ST_VALID});
        check("ep2 in count", {1'b0, hs.count}, 8'h7F);
        rd_check("ep2 tx control", IDX_TXCTL[2], 8'h0E);
        wr(IDX_TXCTL[1], 8'h03);
        host_u.send(3'h1, KIND_IN, 7'h00, hs);
        check("ep1 in count", {1'b0, hs.count}, 8'h0F);
    endtask
    // bus reset clears toggle and status, keeps counts
    task automatic usb_reset();
        logic [7:0] d;
        wr(IDX_EP2RX, 8'h07);
        host_u.hold_reset(1'b1);
        // filter needs four edges and the clear a fifth; six leave margin
        repeat (6) @(posedge clk);
        rd_check("rx2 control cleared", IDX_EP2RX, 8'h00);
        rd_check("rx2 count after reset", IDX_RXC2, 8'h0F);
        host_u.hold_reset(1'b0);
        rd(IDX_ISTAT, d);
        check("reset event flag", d & 8'h02, 8'h02);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        count_regs();
        unmapped();
        out_flow();
        in_flow();
        usb_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
